// file: dv/pmic_control_register_bank_bench.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module pmic_control_register_bank_bench;
  import pmrb_pkg::*;
  typedef struct { pmrb_byte_t addr; pmrb_byte_t exp; } pmrb_row_t;
  logic       ref_clk_i, rst_n_i, en_pin_i, start, stop, bval, rreq, ack, rval;
  logic       c0_on, c0_pwm, c0_dis;
  pmrb_byte_t bdata, rdata, index, pgf, tops, convs, lins, got;
  logic [8:0] load;
  int         error_cnt = 0;
  int         checks_done = 0;
  // reset values, status mirrors and an unmapped place
  pmrb_row_t  rows [11] = '{'{8'h00, 8'h82}, '{8'h01, 8'hA5}, '{8'h02, 8'h07},
    '{8'h15, 8'h00}, '{8'h17, 8'h09}, '{8'h1D, 8'h3C}, '{8'h1E, 8'h5A},
    '{8'h1F, 8'h96}, '{8'h25, 8'h01}, '{8'h26, 8'hC3}, '{8'h30, 8'h00}};
  // id values arbitrary
  pmrb_bank #(.PART_ID(2'h2), .IMAGE_REV(8'hA5)) u_pmrb_bank (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .xfer_start_i(start), .xfer_stop_i(stop), .byte_valid_i(bval),
    .byte_data_i(bdata), .read_req_i(rreq), .byte_ack_o(ack), .read_data_o(rdata),
    .read_valid_o(rval), .en_pin_i(en_pin_i), .power_good_fault_status_i(pgf), .top_stat_i(tops),
    .conv_stat_i(convs), .lin_stat_i(lins), .load_current_i(load), .conv0_on_o(c0_on),
    .conv0_forced_pwm_o(c0_pwm), .conv0_discharge_o(c0_dis), .index_o(index));
  pmrb_host u_pmrb_host (.ref_clk_i(ref_clk_i), .byte_ack_i(ack), .read_valid_i(rval),
    .read_data_i(rdata), .xfer_start_o(start), .xfer_stop_o(stop), .byte_valid_o(bval),
    .byte_data_o(bdata), .read_req_o(rreq));
  // 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  // write control, let pin sync settle, look at the converter on and discharge outputs
  task automatic ctl(input pmrb_byte_t d, input logic pin, input logic on, input logic dis);
    en_pin_i <= pin;
    u_pmrb_host.wr(8'h02, '{d});
    repeat (4) @(posedge ref_clk_i);
    chk({7'h00, c0_on}, {7'h00, on}, "converter on");
    chk({7'h00, c0_dis}, {7'h00, dis}, "discharge");
  endtask
  // hang guard, well beyond the expected run
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    close_out();
  end
  initial begin
    rst_n_i = 1'b0;
    en_pin_i = 1'b1;
    {pgf, tops, convs, lins, load} = {8'hF9, 8'h3C, 8'h5A, 8'h96, 9'h1C3};
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk({5'h00, c0_on, c0_pwm, c0_dis}, 8'h04, "defaults");
    foreach (rows[i]) begin
      u_pmrb_host.rd(rows[i].addr, got);
      chk(got, rows[i].exp, "reset read");
    end
    // burst from a read-only place into control, reserved bits dropped
    u_pmrb_host.wr(8'h01, '{8'h77, 8'hFF});
    // index copy is registered, so let its update land before looking
    @(posedge ref_clk_i);
    chk(index, 8'h03, "index after burst");
    u_pmrb_host.rd(8'h01, got);
    chk(got, 8'hA5, "image version kept");
    chk(u_pmrb_host.ack_cnt[7:0], 8'h0F, "ack count");
    u_pmrb_host.rd(8'h02, got);
    chk(got, 8'h0F, "control burst");
    u_pmrb_host.rd(8'h02, got);
    chk(got, 8'h0F, "repeat read");
    chk(index, 8'h02, "index after reads");
    chk({7'h00, c0_pwm}, 8'h01, "forced pwm");
    ctl(8'h0F, 1'b0, 1'b0, 1'b1);
    ctl(8'h05, 1'b0, 1'b1, 1'b0);
    ctl(8'h04, 1'b1, 1'b0, 1'b1);
    ctl(8'h00, 1'b1, 1'b0, 1'b0);
    u_pmrb_host.wr(8'h00, '{8'h3F});
    u_pmrb_host.rd(8'h00, got);
    chk(got, 8'h82, "part id kept");
    // plain storage takes a write, status ignores one
    u_pmrb_host.wr(8'h24, '{8'h01});
    u_pmrb_host.rd(8'h24, got);
    chk(got, 8'h01, "load select");
    u_pmrb_host.wr(8'h17, '{8'hF0});
    u_pmrb_host.rd(8'h17, got);
    chk(got, 8'h09, "fault status kept");
    // second reset in mid-run restores the control defaults
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    u_pmrb_host.rd(8'h02, got);
    chk(got, 8'h07, "control after reset");
    close_out();
  end
endmodule
`default_nettype wire

// file: dv/pmrb_host.sv
// host model issuing byte transfers to the register bank
`timescale 1ns/100ps
`default_nettype none
module pmrb_host (
  // clock
  input  wire logic                 ref_clk_i,
  // answers from the bank
  input  wire logic                 byte_ack_i,
  input  wire logic                 read_valid_i,
  input  wire pmrb_pkg::pmrb_byte_t read_data_i,
  // requests to the bank
  output logic                      xfer_start_o,
  output logic                      xfer_stop_o,
  output logic                      byte_valid_o,
  output pmrb_pkg::pmrb_byte_t      byte_data_o,
  output logic                      read_req_o
);
  import pmrb_pkg::*;
  int ack_cnt = 0;
  initial begin
    {xfer_start_o, xfer_stop_o, byte_valid_o, read_req_o} = 4'h0;
    byte_data_o = 8'h00;
  end
  // acks are counted, not awaited, since every byte is acked
  always @(posedge ref_clk_i) begin
    if (byte_ack_i === 1'b1) ack_cnt++;
  end
  // one cycle of strobes; idle data lines flip so stale bytes never match
  task automatic step(input logic [3:0] s, input pmrb_byte_t d);
    @(posedge ref_clk_i);
    {xfer_start_o, xfer_stop_o, byte_valid_o, read_req_o} <= s;
    byte_data_o <= s[1] ? d : ~byte_data_o;
  endtask
  // index byte then data bytes, sent as given; the bank drops reserved bits
  task automatic wr(input pmrb_byte_t idx, input pmrb_byte_t d[$]);
    step(4'h8, 8'h00);
    step(4'h2, idx);
    foreach (d[i]) step(4'h2, d[i]);
    step(4'h4, 8'h00);
    step(4'h0, 8'h00);
  endtask
  // set index, restart, one read strobe, take data with the valid pulse
  task automatic rd(input pmrb_byte_t idx, output pmrb_byte_t d);
    step(4'h8, 8'h00);
    step(4'h2, idx);
    step(4'h4, 8'h00);
    step(4'h8, 8'h00);
    step(4'h1, 8'h00);
    step(4'h0, 8'h00);
    @(posedge ref_clk_i);
    d = (read_valid_i === 1'b1) ? read_data_i : 8'hXX;
  endtask
endmodule
`default_nettype wire

// file: verilog/pmrb_bank.sv
// power manager register bank behind the byte-wide serial-host transfer port
// Operation
// - part identifier read-only in bits 7:6
// - config image version read-only at address one
// - forced-pwm bit 3 defaults zero
// - discharge bit 2 applies resistor when off
// - pin gating bit 1 ANDs enable pin
// - enable bit 0 turns converter on
// - bits 7:4 reserved, reset zero
// - write address then data, index increments
// - no index increment during reads
`timescale 1ns/100ps
`default_nettype none
`include "pmrb_consts.svh"

module pmrb_bank #(
  parameter logic [1:0] PART_ID     = 2'h1, // arbitrary value
  parameter logic [7:0] IMAGE_REV   = 8'h5A // arbitrary value
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // transfer port from the serial front end
  input  wire logic              xfer_start_i,
  input  wire logic              xfer_stop_i,
  input  wire logic              byte_valid_i,
  input  wire pmrb_pkg::pmrb_byte_t byte_data_i,
  input  wire logic              read_req_i,
  output logic                   byte_ack_o,
  output pmrb_pkg::pmrb_byte_t   read_data_o,
  output logic                   read_valid_o,
  // pin and analogue status
  input  wire logic              en_pin_i,
  input  wire pmrb_pkg::pmrb_byte_t power_good_fault_status_i,
  input  wire pmrb_pkg::pmrb_byte_t top_stat_i,
  input  wire pmrb_pkg::pmrb_byte_t conv_stat_i,
  input  wire pmrb_pkg::pmrb_byte_t lin_stat_i,
  input  wire logic [8:0]        load_current_i,
  // converter-0 controls and a registered copy of the address index
  output logic                   conv0_on_o,
  output logic                   conv0_forced_pwm_o,
  output logic                   conv0_discharge_o,
  output pmrb_pkg::pmrb_byte_t   index_o
);
  import pmrb_pkg::*;

  pmrb_phase_t phase_q;
  pmrb_byte_t  index_q;
  pmrb_byte_t  conv0_control_q;
  pmrb_byte_t  store_q [0:11];
  logic        en_pin_m_q;
  logic        en_pin_q;
  pmrb_byte_t  power_good_fault_status_m_q, power_good_fault_status_q;
  pmrb_byte_t  top_stat_m_q, top_stat_q;
  pmrb_byte_t  conv_stat_m_q, conv_stat_q;
  pmrb_byte_t  lin_stat_m_q, lin_stat_q;
  logic [8:0]  load_m_q, load_q;
  logic        wr_data;
  logic        conv0_on_d;

  // plain read/write registers kept in a small array, slot per address
  function automatic logic [3:0] slot(input pmrb_byte_t a);
    unique case (a)
      `PMRB_ADDR_PG_CTRL_A:  slot = 4'h0;
      `PMRB_ADDR_PG_CTRL_B:  slot = 4'h1;
      `PMRB_ADDR_SW_RESET:   slot = 4'h2;
      `PMRB_ADDR_TOP_INT_A:  slot = 4'h3;
      `PMRB_ADDR_TOP_INT_B:  slot = 4'h4;
      `PMRB_ADDR_CONV_INT:   slot = 4'h5;
      `PMRB_ADDR_LIN_INT:    slot = 4'h6;
      `PMRB_ADDR_TOP_MASK_A: slot = 4'h7;
      `PMRB_ADDR_TOP_MASK_B: slot = 4'h8;
      `PMRB_ADDR_CONV_MASK:  slot = 4'h9;
      `PMRB_ADDR_LIN_MASK:   slot = 4'hA;
      `PMRB_ADDR_LOAD_SEL:   slot = 4'hB;
      default:               slot = 4'hF;
    endcase
  endfunction

  // pins and analogue flags are asynchronous, two flops before use
  // multi-bit words may tear for a cycle; every bit is a level, so a
  // torn read is still a valid mix of old and new flags
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_pin_m_q    <= 1'b0;
      en_pin_q      <= 1'b0;
      power_good_fault_status_m_q  <= 8'h00;
      power_good_fault_status_q    <= 8'h00;
      top_stat_m_q  <= 8'h00;
      top_stat_q    <= 8'h00;
      conv_stat_m_q <= 8'h00;
      conv_stat_q   <= 8'h00;
      lin_stat_m_q  <= 8'h00;
      lin_stat_q    <= 8'h00;
      load_m_q      <= 9'h000;
      load_q        <= 9'h000;
    end else begin
      en_pin_m_q    <= en_pin_i;
      en_pin_q      <= en_pin_m_q;
      power_good_fault_status_m_q  <= power_good_fault_status_i;
      power_good_fault_status_q    <= power_good_fault_status_m_q;
      top_stat_m_q  <= top_stat_i;
      top_stat_q    <= top_stat_m_q;
      conv_stat_m_q <= conv_stat_i;
      conv_stat_q   <= conv_stat_m_q;
      lin_stat_m_q  <= lin_stat_i;
      lin_stat_q    <= lin_stat_m_q;
      load_m_q      <= load_current_i;
      load_q        <= load_m_q;
    end
  end

  assign wr_data = byte_valid_i && (phase_q == PMRB_PH_DATA);

  // transfer phase: first byte after start is the index, then data bytes
  // stop wins over start so a repeated start never leaves a stale phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= PMRB_PH_IDLE;
    end else if (xfer_stop_i) begin
      phase_q <= PMRB_PH_IDLE;
    end else if (xfer_start_i) begin
      phase_q <= PMRB_PH_ADDR;
    end else if (byte_valid_i && phase_q == PMRB_PH_ADDR) begin
      phase_q <= PMRB_PH_DATA;
    end
  end

  // address index: loaded by the index byte, bumped per data byte only
  // index wraps at the top; a host must not burst past the map end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_q <= 8'h00;
    end else if (byte_valid_i && phase_q == PMRB_PH_ADDR) begin
      index_q <= byte_data_i;
    end else if (wr_data) begin
      index_q <= index_q + 8'h01;
    end
    // reads leave the index where it is
  end

  // every byte received inside a transfer is acknowledged one cycle later
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_ack_o <= 1'b0;
    end else begin
      byte_ack_o <= byte_valid_i && (phase_q != PMRB_PH_IDLE);
    end
  end

  // converter-0 control; reserved bits always stored as zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv0_control_q <= `PMRB_C0_RESET;
    end else if (wr_data && index_q == `PMRB_ADDR_CONV0_CTRL) begin
      conv0_control_q <= byte_data_i & ~`PMRB_C0_RSV_MASK;
    end
  end

  // plain read/write registers; writes to read-only addresses fall through
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 12; i++) begin
        store_q[i] <= 8'h00;
      end
    end else if (wr_data && slot(index_q) != 4'hF) begin
      store_q[slot(index_q)] <= byte_data_i;
    end
  end

  // read path: one registered byte, no state is touched by a read
  // status is two cycles old when read, fine for slow analogue flags
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_data_o  <= 8'h00;
      read_valid_o <= 1'b0;
    end else begin
      read_valid_o <= read_req_i;
      if (read_req_i) begin
        unique case (index_q)
          `PMRB_ADDR_PART_REV:   read_data_o <= {PART_ID, `PMRB_PART_LOW_RESET};
          `PMRB_ADDR_IMAGE_REV:  read_data_o <= IMAGE_REV;
          `PMRB_ADDR_CONV0_CTRL: read_data_o <= conv0_control_q;
          `PMRB_ADDR_POWER_GOOD_FAULT_STATUS:   read_data_o <= power_good_fault_status_q & 8'h0F;
          `PMRB_ADDR_TOP_STAT:   read_data_o <= top_stat_q;
          `PMRB_ADDR_CONV_STAT:  read_data_o <= conv_stat_q;
          `PMRB_ADDR_LIN_STAT:   read_data_o <= lin_stat_q;
          `PMRB_ADDR_LOAD_HIGH:  read_data_o <= {7'h00, load_q[8]};
          `PMRB_ADDR_LOAD_LOW:   read_data_o <= load_q[7:0];
          default: begin
            if (slot(index_q) != 4'hF) begin
              read_data_o <= store_q[slot(index_q)];
            end else begin
              read_data_o <= 8'h00; // unmapped reads as zero
            end
          end
        endcase
      end
    end
  end

  // converter-0 on when enable bit set, and pin too if gating selected
  assign conv0_on_d = conv0_control_q[`PMRB_C0_EN_BIT] &&
                      (!conv0_control_q[`PMRB_C0_PINGATE_BIT] || en_pin_q);

  // registered drive to the converter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv0_on_o         <= 1'b0;
      conv0_forced_pwm_o <= 1'b0;
      conv0_discharge_o  <= 1'b0;
      index_o            <= 8'h00;
    end else begin
      conv0_on_o         <= conv0_on_d;
      conv0_forced_pwm_o <= conv0_control_q[`PMRB_C0_FPWM_BIT];
      // resistor only while the converter is off
      conv0_discharge_o  <= conv0_control_q[`PMRB_C0_DISCH_BIT] && !conv0_on_d;
      index_o            <= index_q;
    end
  end

  // checks
  a_index_incr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_data && !xfer_stop_i && !xfer_start_i |=> index_q == $past(index_q) + 8'h01)
    else $error("index did not advance after data byte");
  a_read_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && !byte_valid_i |=> index_q == $past(index_q))
    else $error("index moved during read");
  a_ack_byte: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    byte_valid_i && phase_q != PMRB_PH_IDLE |=> byte_ack_o)
    else $error("byte not acknowledged");
  a_rsv_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_control_q[7:4] == 4'h0)
    else $error("reserved converter bits set");
  a_part_id: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_PART_REV |=> read_data_o[7:6] == PART_ID)
    else $error("part identifier wrong");
  a_image_rev: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_IMAGE_REV |=> read_data_o == IMAGE_REV)
    else $error("image version wrong");
  a_conv_on: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_control_q[1] && !en_pin_q |=> !conv0_on_o)
    else $error("converter on without pin");
  a_conv_en: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_control_q[0] && !conv0_control_q[1] |=> conv0_on_o)
    else $error("converter off while enabled");
  a_discharge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_discharge_o |-> !conv0_on_o && $past(conv0_control_q[2]))
    else $error("discharge while on");
  a_fpwm: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 conv0_forced_pwm_o == $past(conv0_control_q[3]))
    else $error("forced pwm mismatch");
  a_ro_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_data && index_q == `PMRB_ADDR_IMAGE_REV |=> conv0_control_q == $past(conv0_control_q))
    else $error("read-only write disturbed state");


  // transfer framing and acknowledge
  a_ack_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    byte_valid_i && phase_q == PMRB_PH_IDLE |=> !byte_ack_o)
    else $error("byte acknowledged outside a transfer");
  a_ack_none: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !byte_valid_i |=> !byte_ack_o)
    else $error("acknowledge without a byte");
  a_phase_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    xfer_stop_i |=> phase_q == PMRB_PH_IDLE)
    else $error("stop did not end the transfer");

  // index handling
  a_index_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    byte_valid_i && phase_q == PMRB_PH_ADDR |=> index_q == $past(byte_data_i))
    else $error("index byte not taken");

  // read strobe timing and data hold
  a_read_valid: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1 |=> read_valid_o == $past(read_req_i))
    else $error("read valid not one cycle after strobe");
  a_data_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !read_req_i |=> read_data_o == $past(read_data_o))
    else $error("read data moved without a strobe");

  // converter-0 control register contents
  a_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_data && index_q == `PMRB_ADDR_CONV0_CTRL |=>
      conv0_control_q == ($past(byte_data_i) & 8'h0F))
    else $error("control write not stored");
  a_read_ctrl: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_CONV0_CTRL |=> read_data_o == $past(conv0_control_q))
    else $error("control read wrong");

  // read-only places and storage hold
  a_part_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_PART_REV |=> read_data_o[5:0] == `PMRB_PART_LOW_RESET)
    else $error("part register low bits wrong");
  a_stat_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_TOP_STAT |=> read_data_o == $past(top_stat_q))
    else $error("status read wrong");
  a_load_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_LOAD_HIGH |=> read_data_o[7:1] == 7'h00)
    else $error("load high upper bits set");
  a_unmapped: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q > `PMRB_ADDR_LOAD_LOW |=> read_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_store_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !wr_data |=> store_q[4'hB] == $past(store_q[4'hB]))
    else $error("storage changed without a write");

  // converter-0 drive
  a_dis_on: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_on_o |-> !conv0_discharge_o)
    else $error("discharge applied while running");
  a_dis_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_control_q[2] && !conv0_on_d |=> conv0_discharge_o)
    else $error("discharge missing while off");
  a_off_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !conv0_control_q[0] |=> !conv0_on_o)
    else $error("converter on with enable clear");
  a_en_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_control_q[1:0] == 2'b11 && en_pin_q |=> conv0_on_o)
    else $error("converter off with bit and pin set");

  // main scenarios seen
  c_burst: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_data ##1 wr_data);
  c_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_req_i && index_q == `PMRB_ADDR_CONV0_CTRL);
  c_gated: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_control_q[1] && en_pin_q ##1 conv0_on_o);
  c_discharge: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    conv0_discharge_o);
  c_ro_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_data && index_q == `PMRB_ADDR_IMAGE_REV);
endmodule
`default_nettype wire

// file: verilog/pmrb_consts.svh
// register offsets, field positions, reset values and cycle counts of the register bank
`ifndef PMRB_CONSTS_SVH
`define PMRB_CONSTS_SVH

`define PMRB_ADDR_PART_REV      8'h00
`define PMRB_ADDR_IMAGE_REV     8'h01
`define PMRB_ADDR_CONV0_CTRL    8'h02
`define PMRB_ADDR_PG_CTRL_A     8'h15
`define PMRB_ADDR_PG_CTRL_B     8'h16
`define PMRB_ADDR_POWER_GOOD_FAULT_STATUS      8'h17
`define PMRB_ADDR_SW_RESET      8'h18
`define PMRB_ADDR_TOP_INT_A     8'h19
`define PMRB_ADDR_TOP_INT_B     8'h1A
`define PMRB_ADDR_CONV_INT      8'h1B
`define PMRB_ADDR_LIN_INT       8'h1C
`define PMRB_ADDR_TOP_STAT      8'h1D
`define PMRB_ADDR_CONV_STAT     8'h1E
`define PMRB_ADDR_LIN_STAT      8'h1F
`define PMRB_ADDR_TOP_MASK_A    8'h20
`define PMRB_ADDR_TOP_MASK_B    8'h21
`define PMRB_ADDR_CONV_MASK     8'h22
`define PMRB_ADDR_LIN_MASK      8'h23
`define PMRB_ADDR_LOAD_SEL      8'h24
`define PMRB_ADDR_LOAD_HIGH     8'h25
`define PMRB_ADDR_LOAD_LOW      8'h26

// converter-0 control fields and part register fields
`define PMRB_C0_FPWM_BIT        3
`define PMRB_C0_DISCH_BIT       2
`define PMRB_C0_PINGATE_BIT     1
`define PMRB_C0_EN_BIT          0
`define PMRB_C0_RSV_MASK        8'hF0
`define PMRB_C0_RESET           8'h07
`define PMRB_PART_ID_MSB        7
`define PMRB_PART_ID_LSB        6
`define PMRB_PART_LOW_RESET     6'h02

// read data appears this many cycles after the read strobe
`define PMRB_READ_LATENCY       1

`endif

// file: verilog/pmrb_pkg.sv
// types shared by the power manager register bank
package pmrb_pkg;
  typedef logic [7:0] pmrb_byte_t;
  typedef enum logic [1:0] {
    PMRB_PH_IDLE,
    PMRB_PH_ADDR,
    PMRB_PH_DATA
  } pmrb_phase_t;
endpackage
